// ---- common/synth_prog_pkg.sv ----
// Types shared by the programming port and its reference dividers
package synth_prog_pkg;

   // Applied divide ratio of one synthesizer
   typedef struct packed {
      logic [8:0]  nreg;      // Integer divider field
      logic [17:0] dividend;  // Signed dividend, scaled to 2^18 denominator
      logic [31:0] ratio_q;   // Total divide ratio, 18 fraction bits
   } synth_ratio_t;

   // Modulation sample handed to the modulation unit
   typedef struct packed {
      logic [11:0] word;      // Right-aligned sample bits
      logic [3:0]  len;       // Number of valid bits
   } mod_sample_t;

   // State of one reference divider
   typedef struct packed {
      logic [4:0] cnt;
      logic       tick;
   } ref_div_state_t;

   // State of the programming port
   typedef struct packed {
      logic         sclk;          // Sampled serial clock
      logic         sclk_d;        // Previous sampled serial clock
      logic         cs_n;          // Sampled chip select
      logic         cs_d;          // Previous sampled chip select
      logic         sdata;         // Sampled serial data
      logic         salt;          // Sampled alternate modulation pin
      logic         vco;           // Sampled divided VCO clock
      logic         vco_d;         // Previous sampled divided VCO clock
      logic [15:0]  shift;         // Serial shift register
      logic [11:0]  alt_shift;     // Alternate pin shift register
      logic [4:0]   edges;         // Rising edges seen, saturating
      logic [8:0]   main_div_stg;  // Staged main divider
      logic [7:0]   main_lo_stg;   // Staged low dividend bits
      logic [8:0]   aux_div_stg;   // Staged auxiliary divider
      logic [11:0]  ref_cfg;
      logic [11:0]  pd_cfg;
      logic [11:0]  mux_cfg;
      logic [11:0]  mode_cfg;
      synth_ratio_t main_ratio;
      synth_ratio_t aux_ratio;
      logic         main_upd;
      logic         aux_upd;
      mod_sample_t  mod_stage;
      logic         mod_pend;
      mod_sample_t  mod_out;
      logic         mod_strobe;
      logic         dropped;
      logic         echo_bit;
      logic         mux_q;
      logic         ls_level;
      logic         ls_oe_n;
      logic [3:0]   pulse_cnt;
      logic         pulse_low;
   } prog_state_t;

endpackage

// ---- common/synth_prog_regs.svh ----
// Addresses, field positions, reset values and timing counts of the programming port
`ifndef SYNTH_PROG_REGS_SVH
`define SYNTH_PROG_REGS_SVH

// Word layout of a full serial word
`define WORD_EDGES         5'd16
`define SHORT_MAX_EDGES    5'd12
`define ADDR_MSB           15
`define ADDR_LSB           12
`define DATA_MSB           11

// Register addresses
`define ADDR_MAIN_DIV      4'h0
`define ADDR_MAIN_DVD_HI   4'h1
`define ADDR_MAIN_DVD_LO   4'h2
`define ADDR_AUX_DIV       4'h3
`define ADDR_AUX_DVD       4'h4
`define ADDR_REF_DIV       4'h5
`define ADDR_PD_CTRL       4'h6
`define ADDR_MUX_CTRL      4'h7
`define ADDR_MOD_DATA      4'h8
`define ADDR_MODE_CTRL     4'h9

// Reference divider register fields (ratio = code + 1)
`define REF_MAIN_LSB       0
`define REF_AUX_LSB        5
// Phase detector register fields
`define PD_GAIN_MAIN_LSB   0
`define PD_GAIN_AUX_LSB    5
`define PD_LOCK_SEL_BIT    10
// Multiplexed output select field and codes
`define MUX_SEL_LSB        0
`define MUX_SEL_LOW        2'h0
`define MUX_SEL_ECHO       2'h1
`define MUX_SEL_REF_MAIN   2'h2
`define MUX_SEL_REF_AUX    2'h3
// Mode register bits
`define MODE_MAIN_FRAC_BIT 0
`define MODE_MAIN_18B_BIT  1
`define MODE_AUX_FRAC_BIT  2
`define MODE_MOD_ALT_BIT   3

// Reset values
`define RST_REF_CFG        12'h000
`define RST_PD_CFG         12'h000
`define RST_MUX_CFG        12'h000
`define RST_MODE_CFG       12'h000

// Ratio arithmetic: offset of the divider field and fraction scale
`define NREG_OFFSET        32'h0000_0020
`define FRAC_BITS          18
`define TEN_BIT_PAD        8'h00

// Timing of the out-of-lock pulse train
`define CLK_PERIOD_NS      50
`define LOCK_PULSE_NS      400
`define LOCK_PULSE_CYC     ((`LOCK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- design/ref_div_gen.sv ----
// Programmable divider of the oscillator clock for one phase detector reference
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_regs.svh"

module ref_div_gen
   import synth_prog_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   // Ratio code, divide by code + 1
   input  wire logic [4:0] ratio_code_in,
   // One-cycle reference tick
   output logic            tick_out
);

   ref_div_state_t st_ff;   // Registered state
   ref_div_state_t nxt_st;  // Next state

   // Count up to the code, then emit one tick and restart
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.cnt >= ratio_code_in) begin
         nxt_st.cnt  = 5'h00;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt  = st_ff.cnt + 5'h01;
         nxt_st.tick = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_out = st_ff.tick;

   // After a tick with a steady code of 1, the next one comes two cycles later
   a_tick_period: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (tick_out && $stable(ratio_code_in) && st_ff.cnt == 5'h00 && ratio_code_in == 5'h01)
      |=> !tick_out ##1 tick_out)
      else $error("reference tick period wrong for ratio two");

endmodule
`default_nettype wire

// ---- design/synth_prog_port.sv ----
// Serial programming port and divide-ratio loading of a dual fractional-N synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "synth_prog_regs.svh"

// What this block does
// - Reference dividers per synthesizer, ratio 1..32
// - Five-bit gain step per phase detector
// - Steering mode drives lock/steer output
// - Lock mode: pulse low unlocked, release locked
// - Shift data in on serial clock rise
// - Echo one bit per falling serial edge
// - Long frames keep only final sixteen bits
// - Under thirteen edges: modulation sample only
// - Divider field is nine-bit unsigned
// - Denominator 2^18 or 2^10 by mode
// - Dividend signed, 18 or 10 bits
// - Main ratio times four, auxiliary not
// - Integer mode: field is ratio minus 32
// - 18-bit: high ten bits, low eight
// - 18-bit: apply on dividend high write
// - 10-bit: high register holds all bits
// - Auxiliary applies on its dividend write
// - Integer mode applies on divider write
// - Serial bits resampled on oscillator clock
// - Sample leaves on divided VCO fall
// - Mode bit picks data or alternate pin for short frames
module synth_prog_port
   import synth_prog_pkg::*;
(
   // Clock and reset
   input  wire logic   sys_clk_in,
   input  wire logic   srst_in,
   // Serial programming pins
   input  wire logic   ser_clk_in,
   input  wire logic   ser_data_in,
   input  wire logic   ser_cs_n_in,
   input  wire logic   mod_alt_in,
   // Loop status from the analog side
   input  wire logic   divided_main_vco_clock_in,
   input  wire logic   lock_ok_in,
   input  wire logic   steer_up_in,
   input  wire logic   steer_dn_in,
   // Multiplexed output and lock/steer pin
   output logic        mux_out,
   output logic        lock_steer_out,
   output logic        lock_steer_oe_n_out,
   // Applied ratios
   output synth_ratio_t main_ratio_out,
   output synth_ratio_t aux_ratio_out,
   output logic        main_update_out,
   output logic        aux_update_out,
   // Reference ticks and gains
   output logic        main_ref_tick_out,
   output logic        aux_ref_tick_out,
   output logic [4:0]  main_phase_detector_gain_out,
   output logic [4:0]  aux_phase_detector_gain_out,
   // Modulation sample and frame drop flag
   output mod_sample_t mod_sample_out,
   output logic        mod_strobe_out,
   output logic        frame_dropped_out
);

   prog_state_t st_ff;    // Registered state
   prog_state_t nxt_st;   // Next state
   logic [1:0]  ref_tick; // Ticks of both reference dividers
   logic [4:0]  ref_code [2];
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_rise;
   logic        cs_fall;
   logic        vco_fall;
   logic [3:0]  word_addr;
   logic [11:0] word_data;

   // Edge events are taken from the resampled copies only
   assign sclk_rise = st_ff.sclk & ~st_ff.sclk_d;
   assign sclk_fall = ~st_ff.sclk & st_ff.sclk_d;
   assign cs_rise   = st_ff.cs_n & ~st_ff.cs_d;
   assign cs_fall   = ~st_ff.cs_n & st_ff.cs_d;
   assign vco_fall  = ~st_ff.vco & st_ff.vco_d;
   assign word_addr = st_ff.shift[`ADDR_MSB:`ADDR_LSB];
   assign word_data = st_ff.shift[`DATA_MSB:0];

   // Total ratio with 18 fraction bits, optionally times four
   function automatic logic [31:0] calc_ratio(input logic [8:0]  nreg,
                                              input logic [17:0] dvd,
                                              input logic        quad);
      logic [31:0] whole;
      logic [31:0] sum;
      whole = {23'h000000, nreg} + `NREG_OFFSET;
      sum = (whole << `FRAC_BITS) + {{14{dvd[17]}}, dvd};
      calc_ratio = quad ? (sum << 2) : sum;
   endfunction

   // Reference dividers, one per synthesizer
   assign ref_code[0] = st_ff.ref_cfg[`REF_MAIN_LSB +: 5];
   assign ref_code[1] = st_ff.ref_cfg[`REF_AUX_LSB +: 5];
   for (genvar ch = 0; ch < 2; ch++) begin : g_ref
      ref_div_gen u_ref_div (
         .sys_clk_in    (sys_clk_in),
         .srst_in       (srst_in),
         .ratio_code_in (ref_code[ch]),
         .tick_out      (ref_tick[ch])
      );
   end

   // Next-state logic of the whole port
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk   = ser_clk_in;
      nxt_st.sclk_d = st_ff.sclk;
      nxt_st.cs_n   = ser_cs_n_in;
      nxt_st.cs_d   = st_ff.cs_n;
      nxt_st.sdata  = ser_data_in;
      nxt_st.salt   = mod_alt_in;
      nxt_st.vco    = divided_main_vco_clock_in;
      nxt_st.vco_d  = st_ff.vco;
      // Pulses last one cycle
      nxt_st.main_upd   = 1'b0;
      nxt_st.aux_upd    = 1'b0;
      nxt_st.mod_strobe = 1'b0;
      nxt_st.dropped    = 1'b0;

      // A new frame restarts the edge count
      if (cs_fall) begin
         nxt_st.edges = 5'h00;
      end
      if (sclk_rise && !st_ff.cs_n) begin
         nxt_st.shift     = {st_ff.shift[14:0], st_ff.sdata};
         nxt_st.alt_shift = {st_ff.alt_shift[10:0], st_ff.salt};
         // Saturate so a long frame still reads as a full word
         if (nxt_st.edges < `WORD_EDGES) begin
            nxt_st.edges = nxt_st.edges + 5'h01;
         end
      end
      if (sclk_fall && !st_ff.cs_n) begin
         nxt_st.echo_bit = st_ff.shift[0];
      end

      if (vco_fall && st_ff.mod_pend) begin
         nxt_st.mod_out    = st_ff.mod_stage;
         nxt_st.mod_strobe = 1'b1;
         nxt_st.mod_pend   = 1'b0;
      end

      // Decode the frame once select has risen
      if (cs_rise) begin
         if (st_ff.edges >= `WORD_EDGES) begin
            unique case (word_addr)
               `ADDR_MAIN_DIV: begin
                  nxt_st.main_div_stg = word_data[8:0];
                  if (!st_ff.mode_cfg[`MODE_MAIN_FRAC_BIT]) begin
                     nxt_st.main_ratio.nreg     = word_data[8:0];
                     nxt_st.main_ratio.dividend = 18'h00000;
                     nxt_st.main_ratio.ratio_q  = calc_ratio(word_data[8:0], 18'h00000, 1'b1);
                     nxt_st.main_upd            = 1'b1;
                  end
               end
               `ADDR_MAIN_DVD_LO: begin
                  nxt_st.main_lo_stg = word_data[7:0];
               end
               `ADDR_MAIN_DVD_HI: begin
                  if (st_ff.mode_cfg[`MODE_MAIN_FRAC_BIT]) begin
                     nxt_st.main_ratio.nreg = st_ff.main_div_stg;
                     if (st_ff.mode_cfg[`MODE_MAIN_18B_BIT]) begin
                        nxt_st.main_ratio.dividend = {word_data[9:0], st_ff.main_lo_stg};
                     end else begin
                        nxt_st.main_ratio.dividend = {word_data[9:0], `TEN_BIT_PAD};
                     end
                     nxt_st.main_ratio.ratio_q = calc_ratio(st_ff.main_div_stg,
                                                            nxt_st.main_ratio.dividend, 1'b1);
                     nxt_st.main_upd = 1'b1;
                  end
               end
               `ADDR_AUX_DIV: begin
                  nxt_st.aux_div_stg = word_data[8:0];
                  if (!st_ff.mode_cfg[`MODE_AUX_FRAC_BIT]) begin
                     nxt_st.aux_ratio.nreg     = word_data[8:0];
                     nxt_st.aux_ratio.dividend = 18'h00000;
                     nxt_st.aux_ratio.ratio_q  = calc_ratio(word_data[8:0], 18'h00000, 1'b0);
                     nxt_st.aux_upd            = 1'b1;
                  end
               end
               `ADDR_AUX_DVD: begin
                  if (st_ff.mode_cfg[`MODE_AUX_FRAC_BIT]) begin
                     nxt_st.aux_ratio.nreg     = st_ff.aux_div_stg;
                     nxt_st.aux_ratio.dividend = {word_data[9:0], `TEN_BIT_PAD};
                     nxt_st.aux_ratio.ratio_q  = calc_ratio(st_ff.aux_div_stg,
                                                            {word_data[9:0], `TEN_BIT_PAD}, 1'b0);
                     nxt_st.aux_upd = 1'b1;
                  end
               end
               `ADDR_REF_DIV:   nxt_st.ref_cfg  = word_data;
               `ADDR_PD_CTRL:   nxt_st.pd_cfg   = word_data;
               `ADDR_MUX_CTRL:  nxt_st.mux_cfg  = word_data;
               `ADDR_MODE_CTRL: nxt_st.mode_cfg = word_data;
               `ADDR_MOD_DATA: begin
                  // A full-length sample always comes from the data pin
                  nxt_st.mod_stage.word = word_data;
                  nxt_st.mod_stage.len  = 4'hC;
                  nxt_st.mod_pend       = 1'b1;
               end
               default: begin
                  // Unused addresses are dropped without effect
                  nxt_st.dropped = 1'b1;
               end
            endcase
         end else if (st_ff.edges != 5'h00 && st_ff.edges <= `SHORT_MAX_EDGES) begin
            if (st_ff.mode_cfg[`MODE_MOD_ALT_BIT]) begin
               nxt_st.mod_stage.word = st_ff.alt_shift;
            end else begin
               nxt_st.mod_stage.word = st_ff.shift[11:0];
            end
            // Clear bits left over from earlier frames above the sample length
            nxt_st.mod_stage.word = nxt_st.mod_stage.word & ~(12'hFFF << st_ff.edges[3:0]);
            nxt_st.mod_stage.len = st_ff.edges[3:0];
            nxt_st.mod_pend      = 1'b1;
         end else if (st_ff.edges != 5'h00) begin
            nxt_st.dropped = 1'b1;
         end
      end

      // Multiplexed output source, registered so the pin never glitches
      unique case (st_ff.mux_cfg[`MUX_SEL_LSB +: 2])
         `MUX_SEL_LOW:      nxt_st.mux_q = 1'b0;
         `MUX_SEL_ECHO:     nxt_st.mux_q = st_ff.echo_bit;
         `MUX_SEL_REF_MAIN: nxt_st.mux_q = ref_tick[0];
         `MUX_SEL_REF_AUX:  nxt_st.mux_q = ref_tick[1];
      endcase

      // Out-of-lock pulse train, half period fixed by the pulse count
      if (st_ff.pulse_cnt >= 4'(`LOCK_PULSE_CYC - 1)) begin
         nxt_st.pulse_cnt = 4'h0;
         nxt_st.pulse_low = ~st_ff.pulse_low;
      end else begin
         nxt_st.pulse_cnt = st_ff.pulse_cnt + 4'h1;
      end

      if (st_ff.pd_cfg[`PD_LOCK_SEL_BIT]) begin
         nxt_st.ls_level = 1'b0;
         nxt_st.ls_oe_n  = lock_ok_in | ~st_ff.pulse_low;
      end else begin
         nxt_st.ls_level = steer_up_in;
         nxt_st.ls_oe_n  = ~(steer_up_in | steer_dn_in);
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_ff          <= '0;
         st_ff.cs_n     <= 1'b1;
         st_ff.cs_d     <= 1'b1;
         st_ff.ls_oe_n  <= 1'b1;
         st_ff.ref_cfg  <= `RST_REF_CFG;
         st_ff.pd_cfg   <= `RST_PD_CFG;
         st_ff.mux_cfg  <= `RST_MUX_CFG;
         st_ff.mode_cfg <= `RST_MODE_CFG;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign mux_out                      = st_ff.mux_q;
   assign lock_steer_out               = st_ff.ls_level;
   assign lock_steer_oe_n_out          = st_ff.ls_oe_n;
   assign main_ratio_out               = st_ff.main_ratio;
   assign aux_ratio_out                = st_ff.aux_ratio;
   assign main_update_out              = st_ff.main_upd;
   assign aux_update_out               = st_ff.aux_upd;
   assign main_ref_tick_out            = ref_tick[0];
   assign aux_ref_tick_out             = ref_tick[1];
   assign main_phase_detector_gain_out = st_ff.pd_cfg[`PD_GAIN_MAIN_LSB +: 5];
   assign aux_phase_detector_gain_out  = st_ff.pd_cfg[`PD_GAIN_AUX_LSB +: 5];
   assign mod_sample_out               = st_ff.mod_out;
   assign mod_strobe_out               = st_ff.mod_strobe;
   assign frame_dropped_out            = st_ff.dropped;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   a_shift_rise: assert property (sclk_rise && !st_ff.cs_n
      |=> st_ff.shift[0] == $past(st_ff.sdata))
      else $error("serial bit not shifted on rising edge");

   a_echo_fall: assert property (sclk_fall && !st_ff.cs_n
      && st_ff.mux_cfg[1:0] == `MUX_SEL_ECHO |=> ##1 mux_out == $past(st_ff.shift[0], 2))
      else $error("echo bit not presented after falling edge");

   a_word_load: assert property (cs_rise && st_ff.edges >= `WORD_EDGES
      && word_addr == `ADDR_PD_CTRL |=> main_phase_detector_gain_out == $past(word_data[4:0]))
      else $error("full word did not load addressed register");

   a_short_sample: assert property (cs_rise && st_ff.edges != 5'h00
      && st_ff.edges <= `SHORT_MAX_EDGES |=> st_ff.mod_pend
      && st_ff.mod_stage.len == $past(st_ff.edges[3:0]))
      else $error("short frame not taken as sample");

   a_mid_dropped: assert property (cs_rise && st_ff.edges > `SHORT_MAX_EDGES
      && st_ff.edges < `WORD_EDGES |=> frame_dropped_out && $stable(main_ratio_out)
      && $stable(st_ff.pd_cfg))
      else $error("thirteen to fifteen edge frame changed state");

   a_frac_hold: assert property (cs_rise && st_ff.edges >= `WORD_EDGES
      && st_ff.mode_cfg[0] && word_addr != `ADDR_MAIN_DVD_HI |=> $stable(main_ratio_out))
      else $error("main ratio moved before dividend high write");

   a_int_apply: assert property (cs_rise && st_ff.edges >= `WORD_EDGES
      && !st_ff.mode_cfg[0] && word_addr == `ADDR_MAIN_DIV |=> main_update_out
      && main_ratio_out.ratio_q == (({23'h000000, main_ratio_out.nreg} + 32'h20) << 20))
      else $error("integer divider not applied at once");

   a_mod_handover: assert property (vco_fall && st_ff.mod_pend
      |=> mod_strobe_out && mod_sample_out == $past(st_ff.mod_stage))
      else $error("sample not handed over on VCO fall");

   a_lock_release: assert property (st_ff.pd_cfg[10] && lock_ok_in
      |=> lock_steer_oe_n_out)
      else $error("lock output not released while locked");

   a_steer_drive: assert property (!st_ff.pd_cfg[10] && steer_up_in
      |=> !lock_steer_oe_n_out && lock_steer_out)
      else $error("steering did not drive the pin");

   c_full_word:   cover property (cs_rise && st_ff.edges >= `WORD_EDGES);
   c_short_frame: cover property (cs_rise && st_ff.edges == 5'h04);
   c_frac_apply:  cover property (main_update_out && st_ff.mode_cfg[0]);
   c_out_of_lock: cover property (st_ff.pd_cfg[10] && !lock_steer_oe_n_out);

endmodule
`default_nettype wire

// ---- testbench/host_model.sv ----
// Host model that drives the three-wire programming pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Pacing clock
   input  wire logic sys_clk_in,
   // Serial pins
   output logic      ser_clk_out,
   output logic      ser_data_out,
   output logic      ser_cs_n_out
);
   // Idle pins; serial clock stands still outside frames
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b1;
      ser_cs_n_out = 1'b1;
   end
   task automatic send(input logic [19:0] bits, input int n);
      @(negedge sys_clk_in) ser_cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         ser_data_out = bits[i];
         repeat (2) @(negedge sys_clk_in);
         ser_clk_out = 1'b1;
         repeat (2) @(negedge sys_clk_in);
         ser_clk_out = 1'b0;
      end
      repeat (2) @(negedge sys_clk_in);
      ser_cs_n_out = 1'b1;
      // Deselected data line must not keep showing the last bit
      ser_data_out = ~ser_data_out;
      // Long enough for decode and a three-cycle gap
      repeat (4) @(negedge sys_clk_in);
   endtask
endmodule
`default_nettype wire

// ---- testbench/synth_serial_divider_programming_tb.sv ----
// Testbench for the synthesizer programming port
`timescale 1ns/1ps
`default_nettype none
module synth_serial_divider_programming_tb;
   import synth_prog_pkg::*;
   logic         sys_clk_in = 1'b0;  // Oscillator clock
   logic         srst_in    = 1'b1;  // Reset, held at start
   logic [3:0]   vco_cnt    = 4'h0;  // Slow divided VCO source
   logic         lock_ok    = 1'b0;
   logic         steer_up   = 1'b0;
   wire logic    sclk, sdata, cs_n;
   logic         lso, lso_n, strobe;
   logic [4:0]   gain_m, gain_a;
   synth_ratio_t main_r, aux_r;
   mod_sample_t  samp;
   int           failures = 0;
   int           checked  = 0;
   int           n;
   int           k;
   int           drops    = 0;       // Dropped frames seen
   logic         alt      = 1'b0;    // Alternate sample pin
   logic         mux, drop, mtick;
   always #25 sys_clk_in = ~sys_clk_in;
   // Divided VCO toggles every eight cycles, off the sampling edge
   always @(negedge sys_clk_in) vco_cnt <= vco_cnt + 4'h1;
   // Count drop pulses while they stand
   always @(negedge sys_clk_in) if (drop) drops++;
   host_model host (.sys_clk_in(sys_clk_in), .ser_clk_out(sclk), .ser_data_out(sdata),
      .ser_cs_n_out(cs_n));
   synth_prog_port dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ser_clk_in(sclk),
      .ser_data_in(sdata), .ser_cs_n_in(cs_n), .mod_alt_in(alt),
      .divided_main_vco_clock_in(vco_cnt[3]), .lock_ok_in(lock_ok), .steer_up_in(steer_up),
      .steer_dn_in(1'b0), .mux_out(mux), .lock_steer_out(lso), .lock_steer_oe_n_out(lso_n),
      .main_ratio_out(main_r), .aux_ratio_out(aux_r), .main_update_out(), .aux_update_out(),
      .main_ref_tick_out(mtick), .aux_ref_tick_out(), .main_phase_detector_gain_out(gain_m),
      .aux_phase_detector_gain_out(gain_a), .mod_sample_out(samp), .mod_strobe_out(strobe),
      .frame_dropped_out(drop));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic report_and_stop;
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Bounded wait for the sample strobe; a timeout ends the run
   task automatic wait_strobe;
      int i;
      for (i = 0; i < 100 && strobe !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 100) begin
         failures++;
         report_and_stop();
      end
   endtask
   // Main sequence
   initial begin
      repeat (16) @(negedge sys_clk_in);
      srst_in = 1'b0;
      check(32'(lso_n), 32'h1);
      steer_up = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      check(32'({lso_n, lso}), 32'h1);
      steer_up = 1'b0;
      // Integer mode: divider write applies at once
      host.send({8'h00, 12'd42}, 16);
      check(main_r.ratio_q, 32'(4 * 74 * 262144));
      host.send({8'h03, 12'd18}, 16);
      check(aux_r.ratio_q, 32'(50 * 262144));
      // Over-long frame keeps the last sixteen bits
      host.send({8'hF0, 12'd100}, 20);
      check(32'(main_r.nreg), 32'd100);
      // Fourteen edges load nothing
      host.send({8'h00, 12'd7}, 14);
      check(32'(main_r.nreg), 32'd100);
      // Fractional 18-bit: divider, low, high in order
      host.send({8'h09, 12'h003}, 16);
      host.send({8'h00, 12'd42}, 16);
      host.send({8'h02, 12'h0CC}, 16);
      check(32'(main_r.nreg), 32'd100);
      host.send({8'h01, 12'h305}, 16);
      check(32'(main_r.dividend), 32'h305CC);
      check(main_r.ratio_q, 32'(4 * (74 * 262144 - 64052)));
      // Short frame becomes a modulation sample
      host.send({15'h0, 5'b10110}, 5);
      wait_strobe();
      check(32'(samp), 32'h165);
      // Aux fractional, main 10-bit, samples from alternate pin
      host.send({8'h09, 12'h00D}, 16);
      host.send({8'h03, 12'd18}, 16);
      check(aux_r.ratio_q, 32'(50 * 262144));
      host.send({8'h04, 12'h3BA}, 16);
      check(aux_r.ratio_q, 32'(50 * 262144 - 70 * 256));
      host.send({8'h00, 12'd36}, 16);
      host.send({8'h01, 12'h3BA}, 16);
      check(main_r.ratio_q, 32'(4 * (68 * 262144 - 70 * 256)));
      alt = 1'b1;
      host.send(20'h00000, 3);
      wait_strobe();
      check(32'(samp), 32'h0073);
      alt = 1'b0;
      // Main reference divide by two
      host.send({8'h05, 12'h001}, 16);
      k = 0;
      repeat (10) begin
         @(negedge sys_clk_in);
         k += int'(mtick);
      end
      check(32'(k), 32'd5);
      // Echo select: output shows the last bit shifted
      host.send({8'h07, 12'h001}, 16);
      check(32'(mux), 32'h1);
      host.send({8'h0E, 12'h000}, 16);
      check(32'(mux), 32'h0);
      check(32'(drops), 32'd2);
      // Gains and lock detect mode
      host.send({8'h06, 12'h7FF}, 16);
      check(32'({gain_a, gain_m}), 32'h3FF);
      for (n = 0; n < 100 && lso_n !== 1'b0; n++) @(negedge sys_clk_in);
      if (n == 100) begin
         failures++;
         report_and_stop();
      end
      check(32'(lso), 32'h0);
      lock_ok = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      check(32'(lso_n), 32'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
